/* File: design/tfc_temp_fault_compare.sv */
// Temperature post-processing, threshold compare, fault flags and fault output logic
`timescale 1ns/1ns
`include "tfc_regs.svh"

module tfc_temp_fault_compare #(
  parameter int          NUM_VOLT     = 8,
  parameter bit          HAS_OC       = 1'b1,
  parameter logic [23:0] RST_UNIT_CYC = 24'(`TFC_RST_UNIT_CYC)
) (
  input  wire logic                  clk_in,
  input  wire logic                  rst_b_in,
  input  wire logic                  ce_in,
  input  wire logic [7:0]            reg_addr_in,
  input  wire logic [7:0]            reg_wdata_in,
  input  wire logic                  reg_wr_in,
  input  wire logic                  reg_rd_in,
  output logic      [7:0]            reg_rdata_out,
  input  wire logic                  sweep_done_in,
  input  wire logic [29:0]           temp_raw_in,
  input  wire logic [NUM_VOLT*10-1:0] volt_result_in,
  input  wire logic [7:0]            current_result_in,
  input  wire logic [1:0]            diode_open_in,
  input  wire logic [1:0]            diode_short_in,
  input  wire logic                  oc_primary_in,
  output logic      [1:0]            oc_thresh_sel_out,
  output logic      [5:0]            sense_gain_out,
  output logic      [5:0]            remote1_gain_trim_out,
  output logic      [5:0]            remote2_gain_trim_out,
  output logic                       overtemp_oe_b_out,
  output logic                       overcurrent_oe_b_out,
  output logic                       general_fault_a_oe_b_out,
  output logic                       general_fault_b_oe_b_out,
  output logic                       reset_oe_b_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic tfc_pkg::tfc_temp_t tfc_trim(input tfc_pkg::tfc_temp_t raw, input logic [2:0] code);
    logic signed [11:0] sum;
    sum = 12'(raw) + 12'(signed'(code)) * 12'(signed'({1'b0, `TFC_TRIM_MULT}));
    if (sum > 12'sh1ff)
      return 10'sh1ff;
    else if (sum < -12'sh200)
      return -10'sh200;
    else
      return sum[9:0];
  endfunction : tfc_trim

  function automatic logic tfc_onehot(input logic [7:0] v);
    return (v != 8'h00) && ((v & (v - 8'h01)) == 8'h00);
  endfunction : tfc_onehot

  ////////////////////////////////////////////////////////////////////////////
  // Registers and pin synchronisers

  logic [7:0] gain1, enable, dep_a, dep_b, dep_overtemp_out, dep_rst, rst_tmo;
  logic [7:0] th_pri [3];
  logic [7:0] th_sec [3];
  logic [7:0] th_lsb_r1, trim2, th_lsb_r2, gain2, oc_cfg, oc_th;
  logic [7:0] vov [NUM_VOLT];
  logic [7:0] vuv [NUM_VOLT];
  logic [7:0] flg_ov, flg_uv, flg_temp, flg_cur;
  tfc_pkg::tfc_temp_t res [3];
  logic [4:0] pin_s1, pin_s2;
  logic       oc_latched;
  logic [23:0] rst_cnt;
  tfc_pkg::tfc_rst_state_t rst_state;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_s1 <= 5'h00;
      pin_s2 <= 5'h00;
    end else if (ce_in) begin
      pin_s1 <= {oc_primary_in, diode_short_in, diode_open_in};
      pin_s2 <= pin_s1;
    end
  end

  wire [1:0] dio_open  = pin_s2[1:0];
  wire [1:0] dio_short = pin_s2[3:2];
  wire       oc_pri    = HAS_OC & pin_s2[4] & enable[`TFC_BIT_CUR_EN];

  ////////////////////////////////////////////////////////////////////////////
  // Write decode

  wire wr       = reg_wr_in & ce_in;
  wire clr_ok   = tfc_onehot(reg_wdata_in);
  wire wr_ov    = wr & (reg_addr_in == `TFC_OFF_FLG_OV) & clr_ok;
  wire wr_uv    = wr & (reg_addr_in == `TFC_OFF_FLG_UV) & clr_ok;
  wire wr_temp  = wr & (reg_addr_in == `TFC_OFF_FLG_TEMP) & clr_ok;
  wire wr_cur   = wr & (reg_addr_in == `TFC_OFF_FLG_CUR) & clr_ok;
  wire oc_rel   = wr & (reg_addr_in == `TFC_OFF_OC_CLEAR) & reg_wdata_in[`TFC_BIT_OC_RELEASE];
  wire sweep    = sweep_done_in & ce_in;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      gain1     <= `TFC_RST_ZERO;
      enable    <= `TFC_RST_ZERO;
      dep_a     <= `TFC_RST_ZERO;
      dep_b     <= `TFC_RST_ZERO;
      dep_overtemp_out <= `TFC_RST_ZERO;
      dep_rst   <= `TFC_RST_ZERO;
      rst_tmo   <= `TFC_RST_ZERO;
      th_lsb_r1 <= `TFC_RST_ZERO;
      trim2     <= `TFC_RST_ZERO;
      th_lsb_r2 <= `TFC_RST_ZERO;
      gain2     <= `TFC_RST_ZERO;
      oc_cfg    <= `TFC_RST_ZERO;
      oc_th     <= `TFC_RST_VOV;
      for (int i = 0; i < 3; i++) begin
        th_pri[i] <= `TFC_RST_TH;
        th_sec[i] <= `TFC_RST_TH;
      end
      for (int i = 0; i < NUM_VOLT; i++) begin
        vov[i] <= `TFC_RST_VOV;
        vuv[i] <= `TFC_RST_VUV;
      end
    end else if (wr) begin
      unique case (reg_addr_in)
        `TFC_OFF_GAIN1:     gain1     <= reg_wdata_in;
        `TFC_OFF_ENABLE:    enable    <= reg_wdata_in;
        `TFC_OFF_DEP_A:     dep_a     <= reg_wdata_in;
        `TFC_OFF_DEP_B:     dep_b     <= reg_wdata_in;
        `TFC_OFF_DEP_OVERTEMP_OUT: dep_overtemp_out <= reg_wdata_in;
        `TFC_OFF_DEP_RST:   dep_rst   <= reg_wdata_in;
        `TFC_OFF_RST_TMO:   rst_tmo   <= reg_wdata_in;
        `TFC_OFF_TH_LSB_R1: th_lsb_r1 <= reg_wdata_in;
        `TFC_OFF_TRIM2:     trim2     <= reg_wdata_in;
        `TFC_OFF_TH_LSB_R2: th_lsb_r2 <= reg_wdata_in;
        `TFC_OFF_GAIN2:     gain2     <= reg_wdata_in & `TFC_MSK_GAIN2_RW;
        `TFC_OFF_OC_CFG:    oc_cfg    <= reg_wdata_in;
        `TFC_OFF_OC_TH:     oc_th     <= reg_wdata_in;
        default: begin
          for (int i = 0; i < 3; i++) begin
            if (reg_addr_in == `TFC_OFF_TH_PRI + 8'(i)) th_pri[i] <= reg_wdata_in;
            if (reg_addr_in == `TFC_OFF_TH_SEC + 8'(i)) th_sec[i] <= reg_wdata_in;
          end
          for (int i = 0; i < NUM_VOLT; i++) begin
            if (reg_addr_in == `TFC_OFF_VOV_BASE + 8'(i)) vov[i] <= reg_wdata_in;
            if (reg_addr_in == `TFC_OFF_VUV_BASE + 8'(i)) vuv[i] <= reg_wdata_in;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trim and compare

  wire [2:0] trim_code [3];
  wire [1:0] pri_lsb [3];
  wire [1:0] sec_lsb [3];
  assign trim_code[0] = 3'h0;
  assign trim_code[1] = enable[7:5];
  assign trim_code[2] = trim2[6:4];
  assign pri_lsb[0]   = trim2[1:0];
  assign sec_lsb[0]   = trim2[3:2];
  assign pri_lsb[1]   = th_lsb_r1[1:0];
  assign sec_lsb[1]   = th_lsb_r1[3:2];
  assign pri_lsb[2]   = th_lsb_r2[1:0];
  assign sec_lsb[2]   = th_lsb_r2[3:2];

  wire [2:0] t_pri, t_sec;
  wire [1:0] dio_flt;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_temp
      wire tfc_pkg::tfc_temp_t trimmed = tfc_trim(temp_raw_in[g*10 +: 10], trim_code[g]);
      wire tfc_pkg::tfc_temp_t thp     = {th_pri[g], pri_lsb[g]};
      wire tfc_pkg::tfc_temp_t ths     = {th_sec[g], sec_lsb[g]};
      assign t_pri[g] = enable[g] & (trimmed > thp);
      assign t_sec[g] = enable[g] & (trimmed > ths);
      always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in)
          res[g] <= 10'sh000;
        else if (sweep)
          res[g] <= trimmed;
      end
    end
    for (g = 0; g < 2; g++) begin : g_diode
      assign dio_flt[g] = enable[g+1] & (dio_open[g] | dio_short[g]);
    end
  endgenerate

  wire [NUM_VOLT-1:0] v_ov, v_uv;
  generate
    for (g = 0; g < NUM_VOLT; g++) begin : g_volt
      wire [7:0] vmsb = volt_result_in[g*10+2 +: 8];
      assign v_ov[g] = vmsb > vov[g];
      assign v_uv[g] = vmsb < vuv[g];
    end
  endgenerate

  // Conditions hold from one sweep to the next
  logic [2:0] c_pri, c_sec;
  logic       c_ov, c_uv, c_cur;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      c_pri <= 3'h0;
      c_sec <= 3'h0;
      c_ov  <= 1'b0;
      c_uv  <= 1'b0;
      c_cur <= 1'b0;
    end else if (sweep) begin
      c_pri <= t_pri;
      c_sec <= t_sec;
      c_ov  <= |v_ov;
      c_uv  <= |v_uv;
      c_cur <= HAS_OC & enable[`TFC_BIT_CUR_EN] & (current_result_in > oc_th);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latched flags, set beats clear

  wire [7:0] set_ov   = sweep ? 8'(v_ov) : 8'h00;
  wire [7:0] set_uv   = sweep ? 8'(v_uv) : 8'h00;
  wire [7:0] set_temp = {dio_flt, sweep ? {t_sec, t_pri} : 6'h00};
  wire [7:0] set_cur  = {6'h00, sweep & HAS_OC & enable[`TFC_BIT_CUR_EN] & (current_result_in > oc_th), oc_pri};

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      flg_ov   <= 8'h00;
      flg_uv   <= 8'h00;
      flg_temp <= 8'h00;
      flg_cur  <= 8'h00;
    end else if (ce_in) begin
      flg_ov   <= (flg_ov & ~(wr_ov ? reg_wdata_in : 8'h00)) | set_ov;
      flg_uv   <= (flg_uv & ~(wr_uv ? reg_wdata_in : 8'h00)) | set_uv;
      flg_temp <= (flg_temp & ~(wr_temp ? reg_wdata_in : 8'h00)) | set_temp;
      flg_cur  <= (flg_cur & ~(wr_cur ? reg_wdata_in : 8'h00)) | set_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault outputs

  wire [3:0] cond_vec = {c_cur, |c_sec, c_uv, c_ov};
  wire       ot_cond  = |(dep_overtemp_out[2:0] & c_pri) | (dep_overtemp_out[`TFC_BIT_OVERTEMP_OUT_DIO] & |flg_temp[7:6]);
  wire       fa_cond  = |(dep_a[3:0] & cond_vec);
  wire       fb_cond  = |(dep_b[3:0] & cond_vec);
  wire       rs_cond  = |(dep_rst[3:0] & cond_vec);

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in)
      oc_latched <= 1'b0;
    else if (ce_in)
      oc_latched <= (oc_latched & ~oc_rel) | (oc_pri & oc_cfg[`TFC_BIT_OC_LATCH]);
  end

  wire [23:0] rst_load = 24'(rst_tmo) * RST_UNIT_CYC;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_state <= tfc_pkg::RST_IDLE;
      rst_cnt   <= 24'h000000;
    end else if (ce_in) begin
      unique case (rst_state)
        tfc_pkg::RST_IDLE: begin
          if (rs_cond) rst_state <= tfc_pkg::RST_FAULT;
        end
        tfc_pkg::RST_FAULT: begin
          rst_cnt <= rst_load;
          if (!rs_cond) rst_state <= (rst_load == 24'h000000) ? tfc_pkg::RST_IDLE : tfc_pkg::RST_TIMEOUT;
        end
        tfc_pkg::RST_TIMEOUT: begin
          if (rs_cond)
            rst_state <= tfc_pkg::RST_FAULT;
          else if (rst_cnt <= 24'h000001)
            rst_state <= tfc_pkg::RST_IDLE;
          rst_cnt <= rst_cnt - 24'h000001;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      overtemp_oe_b_out        <= 1'b1;
      overcurrent_oe_b_out     <= 1'b1;
      general_fault_a_oe_b_out <= 1'b1;
      general_fault_b_oe_b_out <= 1'b1;
      reset_oe_b_out           <= 1'b1;
    end else if (ce_in) begin
      overtemp_oe_b_out        <= ~ot_cond;
      overcurrent_oe_b_out     <= ~(HAS_OC & (oc_pri | oc_latched));
      general_fault_a_oe_b_out <= ~fa_cond;
      general_fault_b_oe_b_out <= ~fb_cond;
      reset_oe_b_out           <= ~(rs_cond | rst_state != tfc_pkg::RST_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog controls

  assign oc_thresh_sel_out     = gain1[1:0];
  assign sense_gain_out        = 6'h06 << gain1[1:0];
  assign remote1_gain_trim_out = gain1[7:2] ^ `TFC_MSK_GAIN_INV;
  assign remote2_gain_trim_out = gain2[5:0];

  ////////////////////////////////////////////////////////////////////////////
  // Read mux

  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (reg_addr_in)
      `TFC_OFF_GAIN1:     rd_mux = gain1;
      `TFC_OFF_ENABLE:    rd_mux = enable;
      `TFC_OFF_DEP_A:     rd_mux = dep_a;
      `TFC_OFF_DEP_B:     rd_mux = dep_b;
      `TFC_OFF_DEP_OVERTEMP_OUT: rd_mux = dep_overtemp_out;
      `TFC_OFF_DEP_RST:   rd_mux = dep_rst;
      `TFC_OFF_RST_TMO:   rd_mux = rst_tmo;
      `TFC_OFF_TH_LSB_R1: rd_mux = th_lsb_r1;
      `TFC_OFF_TRIM2:     rd_mux = trim2;
      `TFC_OFF_TH_LSB_R2: rd_mux = th_lsb_r2;
      `TFC_OFF_GAIN2:     rd_mux = gain2;
      `TFC_OFF_OC_CFG:    rd_mux = oc_cfg;
      `TFC_OFF_OC_TH:     rd_mux = oc_th;
      `TFC_OFF_FLG_OV:    rd_mux = flg_ov;
      `TFC_OFF_FLG_UV:    rd_mux = flg_uv;
      `TFC_OFF_FLG_TEMP:  rd_mux = flg_temp;
      `TFC_OFF_FLG_CUR:   rd_mux = flg_cur;
      default: begin
        for (int i = 0; i < 3; i++) begin
          if (reg_addr_in == `TFC_OFF_TH_PRI + 8'(i)) rd_mux = th_pri[i];
          if (reg_addr_in == `TFC_OFF_TH_SEC + 8'(i)) rd_mux = th_sec[i];
          if (reg_addr_in == `TFC_OFF_RES_BASE + 8'(2*i)) rd_mux = res[i][9:2];
          if (reg_addr_in == `TFC_OFF_RES_BASE + 8'(2*i+1)) rd_mux = {6'h00, res[i][1:0]};
        end
        for (int i = 0; i < NUM_VOLT; i++) begin
          if (reg_addr_in == `TFC_OFF_VOV_BASE + 8'(i)) rd_mux = vov[i];
          if (reg_addr_in == `TFC_OFF_VUV_BASE + 8'(i)) rd_mux = vuv[i];
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in)
      reg_rdata_out <= 8'h00;
    else if (ce_in && reg_rd_in)
      reg_rdata_out <= rd_mux;
  end

endmodule : tfc_temp_fault_compare

/* File: design/tfc_regs.svh */
// Register offsets, field positions, reset values and timing counts for the temperature fault block
`ifndef TFC_REGS_SVH
`define TFC_REGS_SVH

`define TFC_OFF_GAIN1      8'h19
`define TFC_OFF_ENABLE     8'h1b
`define TFC_OFF_DEP_A      8'h1d
`define TFC_OFF_DEP_B      8'h1e
`define TFC_OFF_DEP_OVERTEMP_OUT  8'h1f
`define TFC_OFF_DEP_RST    8'h20
`define TFC_OFF_RST_TMO    8'h21
`define TFC_OFF_RES_BASE   8'h30
`define TFC_OFF_TH_PRI     8'h46
`define TFC_OFF_TH_SEC     8'h49
`define TFC_OFF_TH_LSB_R1  8'h4c
`define TFC_OFF_TRIM2      8'h4d
`define TFC_OFF_TH_LSB_R2  8'h4e
`define TFC_OFF_GAIN2      8'h4f
`define TFC_OFF_OC_CLEAR   8'h53
`define TFC_OFF_OC_CFG     8'h5c
`define TFC_OFF_OC_TH      8'h5d
`define TFC_OFF_VOV_BASE   8'h60
`define TFC_OFF_VUV_BASE   8'h68
`define TFC_OFF_FLG_OV     8'h70
`define TFC_OFF_FLG_UV     8'h71
`define TFC_OFF_FLG_TEMP   8'h72
`define TFC_OFF_FLG_CUR    8'h73

`define TFC_BIT_OC_LATCH   2
`define TFC_BIT_OC_RELEASE 6
`define TFC_BIT_CUR_EN     3
`define TFC_BIT_DEP_OV     0
`define TFC_BIT_DEP_UV     1
`define TFC_BIT_DEP_TEMP   2
`define TFC_BIT_DEP_CUR    3
`define TFC_BIT_OVERTEMP_OUT_DIO  3
`define TFC_MSK_GAIN_INV   6'h10
`define TFC_MSK_GAIN2_RW   8'h3f
`define TFC_TRIM_MULT      3'h4

`define TFC_RST_ZERO       8'h00
`define TFC_RST_TH         8'h7f
`define TFC_RST_VUV        8'h00
`define TFC_RST_VOV        8'hff

`define TFC_CLK_PERIOD_NS  10
`define TFC_RST_UNIT_NS    10000
`define TFC_RST_UNIT_CYC   (`TFC_RST_UNIT_NS / `TFC_CLK_PERIOD_NS)

`endif

/* File: design/tfc_pkg.sv */
// Types shared by the temperature fault block
package tfc_pkg;
  typedef logic signed [9:0] tfc_temp_t;
  typedef enum logic [1:0] {RST_IDLE, RST_FAULT, RST_TIMEOUT} tfc_rst_state_t;
endpackage : tfc_pkg

/* File: testbench/tfc_props.sv */
// Port-level checks for the temperature fault block
`timescale 1ns/1ns
module tfc_props (
  input wire logic       clk_in,
  input wire logic       rst_b_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       sweep_done_in,
  input wire logic [1:0] diode_open_in,
  input wire logic [1:0] diode_short_in,
  input wire logic       oc_primary_in,
  input wire logic [1:0] oc_thresh_sel_out,
  input wire logic [5:0] sense_gain_out,
  input wire logic       overtemp_oe_b_out,
  input wire logic       overcurrent_oe_b_out,
  input wire logic       general_fault_a_oe_b_out,
  input wire logic       reset_oe_b_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  logic [2:0] dio_cnt;
  logic [2:0] oc_cnt;
  ////////////////////////////////////////////////////////////
  // Recent-activity windows on the unsynchronised pin inputs
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dio_cnt <= 3'h0;
      oc_cnt  <= 3'h0;
    end else begin
      dio_cnt <= (|{diode_open_in, diode_short_in}) ? 3'h7 : dio_cnt - 3'(dio_cnt != 3'h0);
      oc_cnt  <= oc_primary_in ? 3'h7 : oc_cnt - 3'(oc_cnt != 3'h0);
    end
  end
  ////////////////////////////////////////////////////////////
  sequence oc_quiet;
    (!oc_primary_in) [*4];
  endsequence
  sequence sw_cause;
    $past(sweep_done_in, 2) || $past(reg_wr_in, 2);
  endsequence
  chk_gain_sel_map: assert property (sense_gain_out == (6'h6 << oc_thresh_sel_out))
    else $error("sense gain does not match threshold select");
  chk_gain2_hi_zero: assert property (reg_rd_in && reg_addr_in == 8'h4f |=> reg_rdata_out[7:6] == 2'h0)
    else $error("unused gain bits read nonzero");
  chk_rdata_hold: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data changed without a read");
  chk_oc_release: assert property (
    oc_quiet ##0 (reg_wr_in && reg_addr_in == 8'h53 && reg_wdata_in[6]) |-> ##2 overcurrent_oe_b_out)
    else $error("overcurrent output not released");
  chk_oc_fall_cause: assert property ($fell(overcurrent_oe_b_out) |-> oc_cnt != 3'h0)
    else $error("overcurrent output asserted without a primary trip");
  chk_ovt_fall_cause: assert property ($fell(overtemp_oe_b_out) |-> sw_cause or (dio_cnt != 3'h0))
    else $error("overtemp output asserted without a cause");
  chk_ovt_rise_cause: assert property ($rose(overtemp_oe_b_out) |-> sw_cause)
    else $error("overtemp output released without sweep or software");
  chk_rst_fall_cause: assert property ($fell(reset_oe_b_out) |-> sw_cause)
    else $error("reset output asserted without a cause");
  chk_gfa_fall_cause: assert property ($fell(general_fault_a_oe_b_out) |-> sw_cause)
    else $error("general fault output asserted without a cause");
endmodule : tfc_props

bind tfc_temp_fault_compare tfc_props i_props (.clk_in, .rst_b_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
  .reg_rd_in, .reg_rdata_out, .sweep_done_in, .diode_open_in, .diode_short_in, .oc_primary_in,
  .oc_thresh_sel_out, .sense_gain_out, .overtemp_oe_b_out, .overcurrent_oe_b_out, .general_fault_a_oe_b_out,
  .reset_oe_b_out);

/* File: testbench/tfc_host.sv */
// Host model on the register port of the temperature fault block
`timescale 1ns/1ns
module tfc_host (
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  output logic      [7:0] addr_out,
  output logic      [7:0] wdata_out,
  output logic            wr_out,
  output logic            rd_out
);
  initial begin
    addr_out  = 8'h00;
    wdata_out = 8'h00;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr_out  = a;
    wdata_out = d;
    wr_out    = 1'b1;
    @(negedge clk_in);
    wr_out    = 1'b0;
  endtask : wr
  // Flags are cleared one bit per write
  task automatic clr(input logic [7:0] a, input logic [2:0] b);
    wr(a, 8'h01 << b);
  endtask : clr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_in);
    addr_out = a;
    rd_out   = 1'b1;
    @(negedge clk_in);
    rd_out   = 1'b0;
    d        = rdata_in;
  endtask : rd
endmodule : tfc_host

/* File: testbench/tfc_temp_fault_compare_bench.sv */
// Self-checking bench for the temperature fault block
`timescale 1ns/1ns
module tfc_temp_fault_compare_bench;
  logic        clk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic        ce_in = 1'b1;
  logic        sweep_done_in = 1'b0;
  logic [29:0] temp_raw_in = 30'h0;
  logic [79:0] volt_result_in = 80'h0;
  logic [7:0]  current_result_in = 8'h00;
  logic [1:0]  diode_open_in = 2'h0;
  logic [1:0]  diode_short_in = 2'h0;
  logic        oc_primary_in = 1'b0;
  wire  [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out;
  wire         reg_wr_in, reg_rd_in;
  wire  [1:0]  oc_thresh_sel_out;
  wire  [5:0]  sense_gain_out, remote1_gain_trim_out, remote2_gain_trim_out;
  wire         overtemp_oe_b_out, overcurrent_oe_b_out, reset_oe_b_out;
  wire         general_fault_a_oe_b_out, general_fault_b_oe_b_out;
  int          err_count = 0;
  int          num_checks = 0;
  logic [7:0]  d;
  always #5 clk_in = ~clk_in;
  tfc_temp_fault_compare #(.RST_UNIT_CYC(24'h4)) i_dut (.clk_in, .rst_b_in, .ce_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .sweep_done_in, .temp_raw_in, .volt_result_in, .current_result_in,
    .diode_open_in, .diode_short_in, .oc_primary_in, .oc_thresh_sel_out, .sense_gain_out, .remote1_gain_trim_out,
    .remote2_gain_trim_out, .overtemp_oe_b_out, .overcurrent_oe_b_out, .general_fault_a_oe_b_out,
    .general_fault_b_oe_b_out, .reset_oe_b_out);
  tfc_host i_host (.clk_in, .rdata_in(reg_rdata_out), .addr_out(reg_addr_in), .wdata_out(reg_wdata_in),
    .wr_out(reg_wr_in), .rd_out(reg_rd_in));
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    if (err_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask : cyc
  task automatic sweep(input logic [29:0] t, input logic [79:0] v);
    @(negedge clk_in);
    temp_raw_in    = t;
    volt_result_in = v;
    sweep_done_in  = 1'b1;
    @(negedge clk_in);
    sweep_done_in  = 1'b0;
  endtask : sweep
  // Trimmed, saturated signed compare
  function automatic logic over(input logic [9:0] raw, input logic [2:0] tr, input logic [9:0] th);
    int t;
    t = $signed(raw) + 4 * $signed(tr);
    if (t > 511) t = 511;
    if (t < -512) t = -512;
    return t > $signed(th);
  endfunction : over
  ////////////////////////////////////////////////////////////
  initial begin
    #400000;
    err_count++;
    results();
  end
  initial begin
    logic [9:0] raw[3];
    logic [9:0] th[3];
    logic [2:0] t1, t2, en;
    logic [7:0] v, exp;
    void'($urandom(87901));
    repeat (3) @(negedge clk_in);
    rst_b_in = 1'b1;
    i_host.rd(8'h4f, d);
    check(d, 8'h00);
    i_host.rd(8'hff, d);
    check(d, 8'h00);
    repeat (8) begin
      v = 8'($urandom);
      i_host.wr(8'h19, v);
      i_host.wr(8'h4f, v);
      i_host.rd(8'h4f, d);
      check(d, v & 8'h3f);
      check({6'h0, oc_thresh_sel_out}, {6'h0, v[1:0]});
      check({2'h0, sense_gain_out}, 8'h6 << v[1:0]);
      check({2'h0, remote1_gain_trim_out}, {2'h0, v[7:2] ^ 6'h10});
      check({2'h0, remote2_gain_trim_out}, {2'h0, v[5:0]});
    end
    // Write with clock enable low must not land
    @(negedge clk_in);
    ce_in = 1'b0;
    i_host.wr(8'h19, ~v);
    ce_in = 1'b1;
    i_host.rd(8'h19, d);
    check(d, v);
    i_host.wr(8'h1f, 8'h07);
    repeat (12) begin
      t1 = 3'($urandom);
      t2 = 3'($urandom);
      en = 3'($urandom);
      foreach (raw[i]) begin
        raw[i] = 10'($urandom);
        th[i]  = 10'($urandom);
        i_host.wr(8'h46 + 8'(i), th[i][9:2]);
      end
      i_host.wr(8'h1b, {t1, 2'h0, en});
      i_host.wr(8'h4c, {6'h0, th[1][1:0]});
      i_host.wr(8'h4d, {1'b0, t2, 2'h0, th[0][1:0]});
      i_host.wr(8'h4e, {6'h0, th[2][1:0]});
      for (int i = 0; i < 3; i++) i_host.clr(8'h72, 3'(i));
      sweep({raw[2], raw[1], raw[0]}, 80'h0);
      exp = {5'h0, en[2] & over(raw[2], t2, th[2]), en[1] & over(raw[1], t1, th[1]), en[0] & over(raw[0], 3'h0, th[0])};
      i_host.rd(8'h72, d);
      check(d & 8'h07, exp);
      check({7'h0, overtemp_oe_b_out}, {7'h0, ~|exp});
    end
    // Equal-to-threshold and saturation corners
    for (int k = 0; k < 3; k++) begin
      i_host.wr(8'h1b, {(k == 2) ? 3'h4 : 3'h1, 5'h02});
      i_host.wr(8'h47, (k == 2) ? 8'h80 : 8'h04);
      i_host.wr(8'h4c, 8'h00);
      i_host.clr(8'h72, 3'h1);
      sweep({10'h0, (k == 2) ? 10'h200 : 10'h00c + 10'(k), 10'h0}, 80'h0);
      i_host.rd(8'h72, d);
      check(d & 8'h02, (k == 1) ? 8'h02 : 8'h00);
      if (k == 1) begin
        i_host.wr(8'h72, 8'h03);
        i_host.rd(8'h72, d);
        check(d & 8'h02, 8'h02);
      end
    end
    i_host.wr(8'h1b, 8'h06);
    i_host.wr(8'h1f, 8'h08);
    for (int k = 0; k < 4; k++) begin
      @(negedge clk_in);
      diode_open_in  = k[1] ? 2'h0 : 2'h1 << k[0];
      diode_short_in = k[1] ? 2'h1 << k[0] : 2'h0;
      cyc(5);
      diode_open_in  = 2'h0;
      diode_short_in = 2'h0;
      cyc(4);
      i_host.rd(8'h72, d);
      check(d & 8'hc0, 8'h40 << k[0]);
      check({7'h0, overtemp_oe_b_out}, 8'h00);
      i_host.clr(8'h72, 3'(6 + k[0]));
      cyc(3);
      check({7'h0, overtemp_oe_b_out}, 8'h01);
    end
    i_host.wr(8'h1b, 8'h08);
    for (int k = 0; k < 2; k++) begin
      i_host.wr(8'h5c, (k == 1) ? 8'h04 : 8'h00);
      @(negedge clk_in);
      oc_primary_in = 1'b1;
      cyc(4);
      check({7'h0, overcurrent_oe_b_out}, 8'h00);
      oc_primary_in = 1'b0;
      cyc(5);
      check({7'h0, overcurrent_oe_b_out}, {7'h0, k == 0});
      i_host.wr(8'h53, 8'h40);
      cyc(2);
      check({7'h0, overcurrent_oe_b_out}, 8'h01);
    end
    i_host.wr(8'h1b, 8'h00);
    i_host.wr(8'h60, 8'h10);
    i_host.wr(8'h69, 8'h20);
    i_host.wr(8'h1d, 8'h01);
    i_host.wr(8'h1e, 8'h02);
    i_host.wr(8'h20, 8'h01);
    i_host.wr(8'h21, 8'h02);
    for (int k = 0; k < 3; k++) begin
      sweep(30'h0, {60'h0, (k == 1) ? 10'h000 : 10'h080, (k == 1) ? 10'h044 : 10'h043});
      cyc(2);
      check({7'h0, general_fault_a_oe_b_out}, {7'h0, k != 1});
      check({7'h0, general_fault_b_oe_b_out}, {7'h0, k != 1});
      check({7'h0, reset_oe_b_out}, {7'h0, k == 0});
    end
    cyc(12);
    check({7'h0, reset_oe_b_out}, 8'h01);
    results();
  end
endmodule : tfc_temp_fault_compare_bench
